// *** src/tlm_monitor.sv ***
// Torque and angle supervision of one tightening cycle.
// Assumes torque and angle samples come from mclk-domain logic; trigger is a raw pin.
`timescale 1ns/1ps
`default_nettype none
module tlm_monitor (
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  input  wire logic                    sample_valid,
  input  wire logic [tlm_pkg::TLM_W-1:0] torque,
  input  wire logic [tlm_pkg::TLM_W-1:0] angle,
  input  wire logic                    trigger_pin,
  input  wire logic                    loosening,
  input  wire tlm_pkg::tlm_cfg_type    cfg,
  output var  tlm_pkg::tlm_result_type result
);
  import tlm_pkg::*;

  tlm_state_type    st_reg;
  tlm_state_type    st_next;
  logic             trig_sync;
  logic [TLM_W-1:0] fa_now;
  logic [TLM_W-1:0] ra_now;
  logic             tq_strategy;
  logic             stop;
  logic             nok_now;
  logic [TLM_W-1:0] fin_sel;
  logic [TLM_W-1:0] rep_sel;

  // Trigger is a pin, so it must be synchronised before use
  tlm_sync2 u_trig_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .din   (trigger_pin),
    .dout  (trig_sync)
  );

  // Running angles relative to their origins; wrap is harmless for 16-bit spans
  assign fa_now      = angle - st_reg.fa_origin;
  assign ra_now      = angle - st_reg.rd_origin;
  assign tq_strategy = (cfg.control_strategy_select == TLM_TQ_CON) ||
                       (cfg.control_strategy_select == TLM_TQ_ANG_MON);

  // End-of-cycle figures, chosen by the report and end point selects
  always_comb begin
    unique case (cfg.angle_end_point_select)
      TLM_END_TQ_PEAK:  fin_sel = st_reg.ang_at_peak_tq - st_reg.fa_origin;
      TLM_END_ANG_PEAK: fin_sel = st_reg.peak_ang - st_reg.fa_origin;
      TLM_END_CYC_DONE: fin_sel = fa_now;
      TLM_END_SHUTOFF:  fin_sel = st_reg.shut_ang - st_reg.fa_origin;
    endcase
    if (!st_reg.angle_on) begin
      fin_sel = '0; // No start point seen, so no final angle
    end
    unique case (cfg.torque_report_point)
      TLM_REP_ANG_PEAK: rep_sel = st_reg.tq_at_peak_ang;
      TLM_REP_SHUTOFF:  rep_sel = st_reg.shut_tq;
      default:          rep_sel = st_reg.peak_tq;
    endcase
  end

  // Next-state logic; every comparison is qualified by sample_valid
  always_comb begin
    st_next            = st_reg;
    st_next.done_pulse = 1'b0;
    stop               = 1'b0;
    nok_now            = 1'b0;
    // Trigger edges count only on valid samples; a stale angle would skew the origin
    if (sample_valid) begin
      st_next.trig_prev = trig_sync;
    end
    // Rundown from trigger press, armed while waiting for the cycle
    if (sample_valid && st_reg.phase == TLM_PH_IDLE &&
        cfg.rundown_angle_supervision == TLM_RD_TRIGGER && trig_sync && !st_reg.trig_prev) begin
      st_next.rundown_on   = 1'b1;
      st_next.rundown_done = 1'b0;
      st_next.rd_origin    = angle;
    end
    if (sample_valid) begin
      if (loosening && torque >= cfg.loosening_valid_limit) begin
        st_next.loosen_ok = 1'b1;
      end
      // Peak tracking while the tool runs and coasts down
      if (st_reg.phase == TLM_PH_RUN || st_reg.phase == TLM_PH_OFF) begin
        if (torque > st_reg.peak_tq) begin
          st_next.peak_tq        = torque;
          st_next.ang_at_peak_tq = angle;
        end
        if (angle > st_reg.peak_ang) begin
          st_next.peak_ang       = angle;
          st_next.tq_at_peak_ang = torque;
        end
      end
      unique case (st_reg.phase)
        TLM_PH_IDLE: begin
          if (torque >= cfg.cycle_start_level) begin
            st_next.phase      = TLM_PH_RUN;
            st_next.tool_off   = 1'b0;
            st_next.stage_two  = 1'b0;
            st_next.angle_on   = 1'b0;
            st_next.target_met = 1'b0;
            st_next.nok        = 1'b0;
            st_next.low        = 1'b0;
            st_next.high       = 1'b0;
            // Set beats the clear when the start sample is itself a loosening
            st_next.loosen_ok  = loosening && torque >= cfg.loosening_valid_limit;
            st_next.verdict_ok = 1'b0;
            st_next.peak_tq        = torque;
            st_next.ang_at_peak_tq = angle;
            st_next.peak_ang       = angle;
            st_next.tq_at_peak_ang = torque;
            st_next.shut_tq        = '0;
            st_next.shut_ang       = angle;
            st_next.fa_origin      = angle;
            // Rundown counts only with supervision or the rundown-torque option
            if (cfg.rundown_angle_supervision == TLM_RD_CYCLE ||
                (cfg.rundown_torque_option && !st_reg.rundown_on)) begin
              st_next.rundown_on   = 1'b1;
              st_next.rundown_done = 1'b0;
              st_next.rd_origin    = angle;
            end else if (cfg.rundown_angle_supervision == TLM_RD_NONE &&
                         !cfg.rundown_torque_option) begin
              st_next.rundown_on   = 1'b0;
              st_next.rundown_done = 1'b0;
            end
          end
        end
        TLM_PH_RUN: begin
          if (cfg.two_stage && torque >= cfg.stage_changeover_level) begin
            st_next.stage_two = 1'b1;
          end
          if (st_reg.rundown_on && !st_reg.rundown_done) begin
            if (ra_now > cfg.rundown_angle_maximum) begin
              st_next.high = 1'b1;
              stop         = 1'b1;
            end
            if (torque >= cfg.rundown_complete_level) begin
              st_next.rundown_done = 1'b1;
              if (ra_now < cfg.rundown_angle_minimum) begin
                st_next.low = 1'b1;
                stop        = 1'b1;
              end
            end
          end
          // Final angle origin is the first sample above the start threshold
          if (!st_reg.angle_on && torque > cfg.angle_start_threshold) begin
            st_next.angle_on  = 1'b1;
            st_next.fa_origin = angle;
          end
          if (st_reg.angle_on && fa_now > cfg.final_angle_maximum) begin
            nok_now = 1'b1;
            stop    = 1'b1;
          end
          if (tq_strategy && torque >= cfg.final_torque_target) begin
            st_next.target_met = 1'b1;
            stop               = 1'b1;
          end
          if (cfg.control_strategy_select == TLM_ANG_CON && st_reg.angle_on &&
              fa_now >= cfg.angle_target) begin
            st_next.target_met = 1'b1;
            stop               = 1'b1;
          end
          if (torque > cfg.final_torque_upper_limit) begin
            nok_now = 1'b1;
            stop    = 1'b1;
          end
          if (nok_now) begin
            st_next.nok = 1'b1;
          end
          if (stop) begin
            st_next.tool_off = 1'b1;
            st_next.phase    = TLM_PH_OFF;
            st_next.shut_tq  = torque;
            st_next.shut_ang = angle;
          end
        end
        TLM_PH_OFF: begin
          if (torque <= cfg.cycle_complete_level) begin
            st_next.phase      = TLM_PH_DONE;
            st_next.done_pulse = 1'b1;
            st_next.fin_ang    = fin_sel;
            st_next.rep_tq     = rep_sel;
            // One verdict from the latched nok, low and high flags plus the end checks
            st_next.nok = st_reg.nok || (fin_sel < cfg.final_angle_minimum) ||
                          (rep_sel < cfg.final_torque_lower_limit);
            st_next.verdict_ok = !(st_next.nok || st_reg.low || st_reg.high);
            st_next.rundown_on = 1'b0;
          end
        end
        TLM_PH_DONE: begin
          st_next.phase = TLM_PH_IDLE;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state flops
  always_comb begin
    result.tool_off        = st_reg.tool_off;
    result.stage_two       = st_reg.stage_two;
    result.rundown_done    = st_reg.rundown_done;
    result.angle_active    = st_reg.angle_on;
    result.cycle_done      = st_reg.done_pulse;
    result.verdict_ok      = st_reg.verdict_ok;
    result.nok             = st_reg.nok;
    result.low             = st_reg.low;
    result.high            = st_reg.high;
    result.loosen_ok       = st_reg.loosen_ok;
    result.reported_torque = st_reg.rep_tq;
    result.final_angle     = st_reg.fin_ang;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence run_sample_s;
    sample_valid && st_reg.phase == TLM_PH_RUN;
  endsequence

  sequence coast_below_s;
    sample_valid && st_reg.phase == TLM_PH_OFF && torque <= cfg.cycle_complete_level;
  endsequence

  sequence done_then_idle_s;
    st_reg.phase == TLM_PH_DONE && result.cycle_done;
  endsequence

  tq_target_off_a: assert property (run_sample_s and (tq_strategy &&
      torque >= cfg.final_torque_target) |=> result.tool_off && st_reg.phase == TLM_PH_OFF)
    else $error("torque target did not shut off");

  upper_limit_a: assert property (run_sample_s and (torque > cfg.final_torque_upper_limit)
      |=> result.tool_off && result.nok)
    else $error("upper torque limit not enforced");

  cycle_done_a: assert property (coast_below_s |=> done_then_idle_s ##1
      !result.cycle_done)
    else $error("cycle complete sequence wrong");

  // Done waits for a valid sample before it returns to idle
  done_idle_a: assert property (st_reg.phase == TLM_PH_DONE && sample_valid |=>
      st_reg.phase == TLM_PH_IDLE && !result.cycle_done)
    else $error("done phase did not return to idle");

  angle_start_a: assert property ($rose(result.angle_active) |->
      $past(sample_valid) && $past(torque) > $past(cfg.angle_start_threshold))
    else $error("final angle started below threshold");

  angle_target_a: assert property (run_sample_s and (cfg.control_strategy_select ==
      TLM_ANG_CON && st_reg.angle_on && fa_now >= cfg.angle_target) |=> result.tool_off)
    else $error("angle target did not shut off");

  final_min_a: assert property (result.cycle_done &&
      result.final_angle < cfg.final_angle_minimum |-> result.nok && !result.verdict_ok)
    else $error("short final angle not NOK");

  rundown_high_a: assert property (run_sample_s and (st_reg.rundown_on &&
      !st_reg.rundown_done && ra_now > cfg.rundown_angle_maximum)
      |=> result.high && result.tool_off)
    else $error("rundown high not raised");

  off_hold_a: assert property ($fell(result.tool_off) |->
      $past(st_reg.phase) == TLM_PH_IDLE && st_reg.phase == TLM_PH_RUN)
    else $error("shutoff dropped before cycle start");

  report_peak_a: assert property (coast_below_s and
      (cfg.torque_report_point == TLM_REP_TQ_PEAK) |=> result.reported_torque == $past(st_reg.peak_tq))
    else $error("reported torque is not peak");

  flags_latch_a: assert property (st_reg.phase != TLM_PH_IDLE && result.low |=>
      result.low || st_reg.phase == TLM_PH_RUN)
    else $error("low flag lost within cycle");

  rundown_low_a: assert property (run_sample_s and (st_reg.rundown_on &&
      !st_reg.rundown_done && torque >= cfg.rundown_complete_level &&
      ra_now < cfg.rundown_angle_minimum) |=> result.low && result.tool_off)
    else $error("rundown low not raised");

  rundown_done_a: assert property (run_sample_s and (st_reg.rundown_on &&
      !st_reg.rundown_done && torque >= cfg.rundown_complete_level) |=> result.rundown_done)
    else $error("rundown complete not marked");

  stage_change_a: assert property (run_sample_s and (cfg.two_stage &&
      torque >= cfg.stage_changeover_level) |=> result.stage_two)
    else $error("stage changeover missed");

  cycle_start_a: assert property (sample_valid && st_reg.phase == TLM_PH_IDLE &&
      torque >= cfg.cycle_start_level |=> st_reg.phase == TLM_PH_RUN && !result.tool_off)
    else $error("cycle start not taken");

  loosen_valid_a: assert property (sample_valid && loosening &&
      torque >= cfg.loosening_valid_limit |=> result.loosen_ok)
    else $error("valid loosening not flagged");

  trig_rundown_a: assert property (sample_valid && st_reg.phase == TLM_PH_IDLE &&
      cfg.rundown_angle_supervision == TLM_RD_TRIGGER && trig_sync && !st_reg.trig_prev
      |=> st_reg.rundown_on && !result.rundown_done && st_reg.rd_origin == $past(angle))
    else $error("trigger did not start rundown");

endmodule : tlm_monitor
`default_nettype wire

// *** src/tlm_pkg.sv ***
// Package for the tightening limit monitor: types, defaults and result layout.
// Assumes torque in Nm and angle in degrees as unsigned 16-bit sample values.
package tlm_pkg;

  localparam int TLM_W = 16;

  // Control strategy families that matter to shutoff
  typedef enum logic [1:0] {
    TLM_TQ_CON     = 2'b00,
    TLM_TQ_ANG_MON = 2'b01,
    TLM_ANG_CON    = 2'b10
  } tlm_strategy_type;

  typedef enum logic [1:0] {
    TLM_REP_TQ_PEAK  = 2'b00,
    TLM_REP_ANG_PEAK = 2'b01,
    TLM_REP_SHUTOFF  = 2'b10
  } tlm_report_type;

  typedef enum logic [1:0] {
    TLM_END_TQ_PEAK  = 2'b00,
    TLM_END_ANG_PEAK = 2'b01,
    TLM_END_CYC_DONE = 2'b10,
    TLM_END_SHUTOFF  = 2'b11
  } tlm_angle_end_type;

  typedef enum logic [1:0] {
    TLM_RD_NONE    = 2'b00,
    TLM_RD_TRIGGER = 2'b01,
    TLM_RD_CYCLE   = 2'b10
  } tlm_rundown_type;

  typedef enum logic [1:0] {
    TLM_PH_IDLE = 2'b00,
    TLM_PH_RUN  = 2'b01,
    TLM_PH_OFF  = 2'b10,
    TLM_PH_DONE = 2'b11
  } tlm_phase_type;

  // Default settings, percent of tool max torque or absolute values
  localparam logic [TLM_W-1:0] TLM_DEF_FINAL_TARGET = 16'h270f; // 9999 Nm
  localparam int               TLM_PCT_UPPER        = 50;
  localparam int               TLM_PCT_CYC_DONE     = 3;
  localparam int               TLM_PCT_RUNDOWN      = 20;
  localparam int               TLM_PCT_LOOSEN       = 10;
  localparam int               TLM_PCT_ANG_START    = 25;
  localparam int               TLM_PCT_CYC_START    = 5;
  localparam int               TLM_PCT_CHANGEOVER   = 25;
  localparam int               TLM_PCT_LOWER        = 30;
  localparam int               TLM_PCT_DEN          = 100;
  localparam logic [TLM_W-1:0] TLM_DEF_ANG_MIN      = 16'h0000; // 0 deg
  localparam logic [TLM_W-1:0] TLM_DEF_ANG_TARGET   = 16'h0000; // 0 deg
  localparam logic [TLM_W-1:0] TLM_DEF_ANG_MAX      = 16'h270f; // 9999 deg

  typedef struct packed {
    tlm_strategy_type  control_strategy_select;
    logic              two_stage;
    logic [TLM_W-1:0]  final_torque_target;
    logic [TLM_W-1:0]  final_torque_upper_limit;
    logic [TLM_W-1:0]  final_torque_lower_limit;
    logic [TLM_W-1:0]  cycle_complete_level;
    logic [TLM_W-1:0]  rundown_complete_level;
    logic [TLM_W-1:0]  cycle_start_level;
    logic [TLM_W-1:0]  stage_changeover_level;
    tlm_report_type    torque_report_point;
    logic [TLM_W-1:0]  loosening_valid_limit;
    logic [TLM_W-1:0]  angle_start_threshold;
    tlm_angle_end_type angle_end_point_select;
    logic [TLM_W-1:0]  final_angle_minimum;
    logic [TLM_W-1:0]  angle_target;
    logic [TLM_W-1:0]  final_angle_maximum;
    logic [TLM_W-1:0]  rundown_angle_minimum;
    logic [TLM_W-1:0]  rundown_angle_maximum;
    tlm_rundown_type   rundown_angle_supervision;
    logic              rundown_torque_option;
  } tlm_cfg_type;

  typedef struct packed {
    logic             tool_off;
    logic             stage_two;
    logic             rundown_done;
    logic             angle_active;
    logic             cycle_done;
    logic             verdict_ok;
    logic             nok;
    logic             low;
    logic             high;
    logic             loosen_ok;
    logic [TLM_W-1:0] reported_torque;
    logic [TLM_W-1:0] final_angle;
  } tlm_result_type;

  // Percent of tool max torque, truncated toward zero
  function automatic logic [TLM_W-1:0] tlm_pct(input logic [TLM_W-1:0] tmax, input int pct);
    int prod;
    prod = (int'(tmax) * pct) / TLM_PCT_DEN;
    return prod[TLM_W-1:0];
  endfunction : tlm_pct

  // Full default setting for a given tool max torque
  function automatic tlm_cfg_type tlm_default_cfg(input logic [TLM_W-1:0] tool_max_torque);
    tlm_cfg_type c;
    c.control_strategy_select   = TLM_TQ_ANG_MON;
    c.two_stage                 = 1'b1;
    c.final_torque_target       = TLM_DEF_FINAL_TARGET;
    c.final_torque_upper_limit  = tlm_pct(tool_max_torque, TLM_PCT_UPPER);
    c.final_torque_lower_limit  = tlm_pct(tool_max_torque, TLM_PCT_LOWER);
    c.cycle_complete_level      = tlm_pct(tool_max_torque, TLM_PCT_CYC_DONE);
    c.rundown_complete_level    = tlm_pct(tool_max_torque, TLM_PCT_RUNDOWN);
    c.cycle_start_level         = tlm_pct(tool_max_torque, TLM_PCT_CYC_START);
    c.stage_changeover_level    = tlm_pct(tool_max_torque, TLM_PCT_CHANGEOVER);
    c.torque_report_point       = TLM_REP_TQ_PEAK;
    c.loosening_valid_limit     = tlm_pct(tool_max_torque, TLM_PCT_LOOSEN);
    c.angle_start_threshold     = tlm_pct(tool_max_torque, TLM_PCT_ANG_START);
    c.angle_end_point_select    = TLM_END_ANG_PEAK;
    c.final_angle_minimum       = TLM_DEF_ANG_MIN;
    c.angle_target              = TLM_DEF_ANG_TARGET;
    c.final_angle_maximum       = TLM_DEF_ANG_MAX;
    c.rundown_angle_minimum     = TLM_DEF_ANG_MIN;
    c.rundown_angle_maximum     = TLM_DEF_ANG_MAX;
    c.rundown_angle_supervision = TLM_RD_NONE;
    c.rundown_torque_option     = 1'b0;
    return c;
  endfunction : tlm_default_cfg

  // Register state of the monitor
  typedef struct packed {
    tlm_phase_type    phase;
    logic             trig_prev;
    logic             tool_off;
    logic             stage_two;
    logic             rundown_on;
    logic             rundown_done;
    logic             angle_on;
    logic             target_met;
    logic [TLM_W-1:0] rd_origin;
    logic [TLM_W-1:0] fa_origin;
    logic [TLM_W-1:0] peak_tq;
    logic [TLM_W-1:0] ang_at_peak_tq;
    logic [TLM_W-1:0] peak_ang;
    logic [TLM_W-1:0] tq_at_peak_ang;
    logic [TLM_W-1:0] shut_tq;
    logic [TLM_W-1:0] shut_ang;
    logic             nok;
    logic             low;
    logic             high;
    logic             loosen_ok;
    logic             done_pulse;
    logic             verdict_ok;
    logic [TLM_W-1:0] rep_tq;
    logic [TLM_W-1:0] fin_ang;
  } tlm_state_type;

endpackage : tlm_pkg

// *** src/tlm_sync2.sv ***
// Two-flop synchroniser for one level from outside the mclk domain.
// Assumes the level is slow against mclk; a pulse that no mclk edge samples, as one shorter than a cycle can be, is lost.
`timescale 1ns/1ps
`default_nettype none
module tlm_sync2 (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic din,
  output var  logic dout
);
  typedef struct packed {
    logic meta;
    logic stable;
  } tlm_sync_type;

  tlm_sync_type sync_reg;
  tlm_sync_type sync_next;

  // First flop feeds only the second
  always_comb begin
    sync_next.meta   = din;
    sync_next.stable = sync_reg.meta;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign dout = sync_reg.stable;
endmodule : tlm_sync2
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench: whole tightening cycles against the tool model.
// Assumes tool max torque 1000 Nm, so percent defaults are whole numbers.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tlm_pkg::*;
  logic           mclk = 1'b0;
  logic           rst_n = 1'b0;
  logic           go = 1'b0;
  logic           trig = 1'b0;
  logic           loos = 1'b0;
  logic [15:0]    tqs = 16'h0007;
  logic [15:0]    angs = 16'h0003;
  tlm_cfg_type    c;
  tlm_cfg_type    b;
  tlm_cfg_type    s;
  tlm_result_type r;
  wire logic        sv;
  wire logic [15:0] tq;
  wire logic [15:0] an;
  int failures = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [15:0] pk_tq, pk_tq_ang, pk_ang, pk_ang_tq, sh_tq, sh_ang, org, last_ang;
  logic        org_ok, sh_ok;

  tlm_monitor dut_u (.mclk(mclk), .rst_n(rst_n), .sample_valid(sv), .torque(tq), .angle(an),
    .trigger_pin(trig), .loosening(loos), .cfg(c), .result(r));
  tlm_tool_model tool_u (.mclk(mclk), .rst_n(rst_n), .go(go), .tq_step(tqs), .ang_step(angs),
    .tool_off(r.tool_off), .sample_valid(sv), .torque(tq), .angle(an));

  always #10 mclk = ~mclk;
  // Hang guard; a full run needs about 1100 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end
  // Reference tracking of what the tool delivered
  always @(posedge mclk) begin
    if (go && sv) begin
      if (tq > pk_tq) begin
        pk_tq = tq;
        pk_tq_ang = an;
      end
      if (an > pk_ang) begin
        pk_ang = an;
        pk_ang_tq = tq;
      end
      if (!org_ok && tq > c.angle_start_threshold) begin
        org = an;
        org_ok = 1'b1;
      end
      if (!sh_ok && tq >= c.final_torque_target) begin
        sh_tq = tq;
        sh_ang = an;
        sh_ok = 1'b1;
      end
      last_ang = an;
    end
  end

  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One whole cycle; flags expected by caller, values from tracking
  task automatic run(input tlm_cfg_type cf, input logic [15:0] ts, input logic ls,
                     input logic nk, input logic lw, input logic hi, input logic vals);
    int n;
    logic [15:0] er;
    logic [15:0] ea;
    @(posedge mclk);
    c <= cf;
    tqs <= ts;
    loos <= ls;
    pk_tq = 0;
    pk_ang = 0;
    org_ok = 0;
    sh_ok = 0;
    @(posedge mclk);
    go <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (r.cycle_done !== 1'b1 && n < 600);
    chk("cycle_done", r.cycle_done, 1'b1);
    chk("tool_off", r.tool_off, 1'b1);
    chk("nok", r.nok, nk);
    chk("low", r.low, lw);
    chk("high", r.high, hi);
    chk("verdict_ok", r.verdict_ok, !(nk | lw | hi));
    chk("loosen_ok", r.loosen_ok, ls);
    er = (c.torque_report_point == TLM_REP_ANG_PEAK) ? pk_ang_tq :
         (c.torque_report_point == TLM_REP_SHUTOFF) ? sh_tq : pk_tq;
    case (c.angle_end_point_select)
      TLM_END_TQ_PEAK:  ea = pk_tq_ang - org;
      TLM_END_CYC_DONE: ea = last_ang - org;
      TLM_END_SHUTOFF:  ea = sh_ang - org;
      default:          ea = pk_ang - org;
    endcase
    if (vals) begin
      chk("reported_torque", r.reported_torque, er);
      chk("final_angle", r.final_angle, ea);
    end
    @(posedge mclk);
    go <= 1'b0;
    loos <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : run

  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  initial begin
    b = tlm_default_cfg(16'h03e8);
    c = b;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    // Defaults: upper limit 500 stops a 9999 target
    run(b, 16'h0007, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    chk("upper_stop", pk_tq <= 16'd511, 1'b1);
    chk("angle_active", r.angle_active, 1'b1);
    b.control_strategy_select = TLM_TQ_CON;
    b.final_torque_target = 16'd400;
    // Settings built aside; run hands them to the design on a clock edge
    for (int i = 0; i < 4; i++) begin
      s = b;
      s.torque_report_point = tlm_report_type'(i % 3);
      s.angle_end_point_select = tlm_angle_end_type'(i);
      run(s, 16'h0007, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
      chk("target_stop", pk_tq <= 16'd413, 1'b1);
      chk("stage_two", r.stage_two, 1'b1);
    end
    // Angle control, peak torque stays under the lower limit
    s = b;
    s.control_strategy_select = TLM_ANG_CON;
    s.angle_target = 16'd30;
    s.angle_end_point_select = TLM_END_SHUTOFF;
    run(s, 16'h0004, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    chk("angle_target", r.final_angle, 16'd30);
    // One stage: torque passes the changeover level without switching
    s = b;
    s.two_stage = 1'b0;
    s.final_angle_maximum = 16'd20;
    run(s, 16'h0007, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    chk("angle_max_stop", pk_tq < 16'd400, 1'b1);
    chk("one_stage", r.stage_two, 1'b0);
    s = b;
    s.final_angle_minimum = 16'h270f;
    run(s, 16'h0007, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    s = b;
    s.rundown_angle_supervision = TLM_RD_CYCLE;
    s.rundown_angle_minimum = 16'd1000;
    run(s, 16'h0007, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    chk("rundown_done", r.rundown_done, 1'b1);
    chk("low_stop", pk_tq < 16'd400, 1'b1);
    chk("angle_idle", r.angle_active, 1'b0);
    s.rundown_angle_minimum = 16'h0000;
    s.rundown_angle_maximum = 16'd10;
    run(s, 16'h0007, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    chk("high_stop", pk_tq < 16'd200, 1'b1);
    // Rundown from the press: origin is early, so high trips at once
    s = b;
    s.rundown_angle_supervision = TLM_RD_TRIGGER;
    s.rundown_angle_maximum = 16'd15;
    trig <= 1'b1;
    run(s, 16'h0007, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    chk("trigger_stop", pk_tq < 16'd80, 1'b1);
    trig <= 1'b0;
    results();
  end
endmodule : testbench
`default_nettype wire

// *** testbench/tlm_tool_model.sv ***
// Behavioural tightening tool: ramps torque and angle once per cycle while run.
// Assumes tool_off comes from the monitor; torque relaxes after the stop.
`timescale 1ns/1ps
`default_nettype none
module tlm_tool_model (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire logic                      go,
  input  wire logic [tlm_pkg::TLM_W-1:0] tq_step,
  input  wire logic [tlm_pkg::TLM_W-1:0] ang_step,
  input  wire logic                      tool_off,
  output var  logic                      sample_valid,
  output wire logic [tlm_pkg::TLM_W-1:0] torque,
  output wire logic [tlm_pkg::TLM_W-1:0] angle
);
  import tlm_pkg::*;
  logic [TLM_W-1:0] tq_reg;
  logic [TLM_W-1:0] ang_reg;
  // A stop left from the last cycle stands until the next cycle start,
  // so the tool obeys a stop only after seeing the command low this run
  logic             armed_reg;
  // No sample outside a run, so stale values are inverted
  assign torque = sample_valid ? tq_reg : ~tq_reg;
  assign angle  = sample_valid ? ang_reg : ~ang_reg;
  // Spindle turns until commanded off; a stop is ignored until the command has been seen low this run
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sample_valid <= 1'b0;
      tq_reg       <= 16'h0000;
      ang_reg      <= 16'h0000;
      armed_reg    <= 1'b0;
    end else if (!go) begin
      sample_valid <= 1'b0;
      tq_reg       <= 16'h0000;
      armed_reg    <= 1'b0;
    end else begin
      sample_valid <= 1'b1;
      if (!tool_off) begin
        armed_reg <= 1'b1;
      end
      if (!(tool_off && armed_reg)) begin
        tq_reg  <= tq_reg + tq_step;
        ang_reg <= ang_reg + ang_step;
      end else begin
        tq_reg <= (tq_reg > tq_step) ? tq_reg - tq_step : 16'h0000;
      end
    end
  end
endmodule : tlm_tool_model
`default_nettype wire
